// >>> usb_dma_port.v
// Two-channel DMA request port with local register access and pin modes.
`timescale 1ns/1ns
`include "usb_dma_regs.vh"

module usb_dma_port (
  input wire mclk,
  input wire reset,
  input wire bus_mux_select_pin,
  input wire latch_or_pullup_pin_i,
  output reg latch_or_pullup_pin_o,
  output reg latch_or_pullup_pin_oe,
  input wire dplus_pullup_ctrl,
  input wire [7:0] ad_in,
  input wire [6:0] reg_addr,
  input wire cs_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg dma_req_ch0,
  output reg dma_req_ch1,
  input wire dma_ack_ch0,
  input wire dma_ack_ch1,
  input wire xfer_strobe,
  input wire [15:0] dma_data_i,
  output reg [15:0] dma_data_o,
  input wire irq_src,
  output reg irq_out,
  output reg [3:0] chan_ep,
  input wire [3:0] ep_is_tx,
  input wire [3:0] tx_fifo_free,
  input wire [3:0] tx_pkt_ready,
  input wire [3:0] rx_pkt_ready,
  input wire [31:0] rx_byte_count,
  input wire [31:0] max_pkt_size,
  input wire [15:0] rxf_data,
  input wire [1:0] rxf_valid,
  output wire [1:0] rxf_pop,
  output wire [31:0] txf_data,
  output wire [1:0] txf_push,
  output wire [1:0] txf_two,
  output reg [3:0] tx_set_pkt_ready
);
  localparam [11:0] BIT_CYC = `BIT_CYC;
  localparam [11:0] REQ_EN_CYC = `REQ_EN_CYC;

  reg [15:0] ctl_r;
  reg [15:0] intvl_r;
  reg [7:0] pol_r;
  reg ale_d_r;
  reg [6:0] addr_lat_r;
  reg cs_lat_r;

  wire [1:0] req_raw;
  wire [1:0] set_w;
  wire [1:0] busy_w;
  wire [31:0] bout_w;
  wire same_ep = ctl_r[6:5] == ctl_r[14:13];
  wire ack0_lvl = dma_ack_ch0 ^ pol_r[`POL_ACK0];
  wire ack1_lvl = dma_ack_ch1 ^ pol_r[`POL_ACK1];
  wire [1:0] ack_act;

  // Shared endpoint: either acknowledge serves channel 0, which then runs both pins.
  assign ack_act[0] = ack0_lvl | (same_ep & ack1_lvl);
  assign ack_act[1] = ack1_lvl;

  wire mux = bus_mux_select_pin;
  wire sel = mux ? ~cs_lat_r : ~cs_n;
  wire [6:0] addr = mux ? addr_lat_r : reg_addr;

  // Address and select are taken at the falling edge of the latch strobe.
  always @(posedge mclk) begin
    if (reset) begin
      ale_d_r <= 1'b0;
      addr_lat_r <= 7'h00;
      cs_lat_r <= 1'b1;
    end else begin
      ale_d_r <= latch_or_pullup_pin_i;
      if (mux & ale_d_r & ~latch_or_pullup_pin_i) begin
        addr_lat_r <= ad_in[6:0];
        cs_lat_r <= cs_n;
      end
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      ctl_r <= {`RST_CTL, `RST_CTL};
      intvl_r <= {`RST_INTVL, `RST_INTVL};
      pol_r <= `RST_POL;
      reg_rdata <= 8'h00;
    end else begin
      if (sel & reg_wr) begin
        case (addr)
          `OFF_CH0_CTL: ctl_r[7:0] <= reg_wdata;
          `OFF_CH0_INTVL: intvl_r[7:0] <= reg_wdata;
          `OFF_CH1_CTL: ctl_r[15:8] <= reg_wdata;
          `OFF_CH1_INTVL: intvl_r[15:8] <= reg_wdata;
          `OFF_POLARITY: pol_r <= {3'h0, reg_wdata[4:0]};
          default: ;
        endcase
      end
      if (sel & reg_rd) begin
        case (addr)
          `OFF_CH0_CTL: reg_rdata <= ctl_r[7:0];
          `OFF_CH0_INTVL: reg_rdata <= intvl_r[7:0];
          `OFF_CH1_CTL: reg_rdata <= ctl_r[15:8];
          `OFF_CH1_INTVL: reg_rdata <= intvl_r[15:8];
          `OFF_POLARITY: reg_rdata <= pol_r;
          `OFF_DMA_STATUS: reg_rdata <= {4'h0, busy_w, req_raw};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : chan
      wire [7:0] ctl = ctl_r[c*8 +: 8];
      wire [7:0] intvl = intvl_r[c*8 +: 8];
      wire [1:0] ep = ctl[`CTL_EP_HI:`CTL_EP_LO];
      wire en = ctl[`CTL_EN] & ((c == 1) ? ~same_ep : 1'b1);
      wire tx = ep_is_tx[ep];
      wire dual = ctl[`CTL_DUAL];
      wire wide = ctl[`CTL_WIDE];
      wire demand = ctl[`CTL_DEMAND];
      wire pause = ctl[`CTL_PAUSE];
      wire [7:0] max_sz = max_pkt_size[ep*8 +: 8];
      wire [7:0] cnt_in = rx_byte_count[ep*8 +: 8];
      wire [7:0] byte_in = rxf_data[c*8 +: 8];
      wire [11:0] gap_load = intvl * BIT_CYC + REQ_EN_CYC;
      wire pri = (c == 0) ? 1'b1 : ~(req_raw[0] & ctl_r[`CTL_DUAL]);

      reg req_r;
      reg [11:0] gap_r;
      reg rx_act_r;
      reg done_r;
      reg ins_r;
      reg have_lo_r;
      reg [7:0] lo_r;
      reg [7:0] rem_r;
      reg pop_r;
      reg [7:0] wcnt_r;
      reg wait_r;
      reg push_r;
      reg two_r;
      reg [15:0] txd_r;

      wire bin_ready;
      wire bout_valid;
      wire [15:0] bout_data;
      // Dual-address cycles carry no acknowledge; the strobe completes them, on channel 1 only while channel 0 has no dual request pending.
      wire xfer = xfer_strobe & req_r & (dual ? pri : ack_act[c]);
      wire last = rem_r == 8'h01;
      wire byte_ok = rx_act_r & ~ins_r & (rem_r != 8'h00) & rxf_valid[c] & ~pop_r;
      wire hold_lo = wide & ~have_lo_r & ~last;
      wire take = byte_ok & (hold_lo | bin_ready);
      wire bin_valid = ins_r ? rx_act_r : (byte_ok & ~hold_lo);
      wire [15:0] bin_data;
      assign bin_data = ins_r ? {8'h00, cnt_in} :
                        (have_lo_r ? {byte_in, lo_r} : {8'h00, byte_in});
      wire rx_end = rx_act_r & ~ins_r & (rem_r == 8'h00) & ~have_lo_r & ~bout_valid;
      wire tx_ok = tx & tx_fifo_free[ep] & ~tx_pkt_ready[ep] & ~wait_r;
      wire [8:0] wsum = {1'b0, wcnt_r} + {7'h00, wide, ~wide};
      wire full = wsum >= {1'b0, max_sz};
      wire set_c = xfer & tx & full;
      wire rx_want = demand ? rx_act_r : bout_valid;
      wire req_nxt = en & ~pause & (demand | (gap_r == 12'h000)) &
                     (tx ? tx_ok : rx_want) & ~(xfer & ~demand);

      dma_buf2 #(
        .W(16)
      ) u_buf (
        .mclk(mclk),
        .reset(reset),
        .in_valid(bin_valid),
        .in_ready(bin_ready),
        .in_data(bin_data),
        .out_valid(bout_valid),
        .out_ready(xfer & ~tx),
        .out_data(bout_data)
      );

      always @(posedge mclk) begin
        if (reset) begin
          req_r <= 1'b0;
          gap_r <= 12'h000;
          rx_act_r <= 1'b0;
          done_r <= 1'b0;
          ins_r <= 1'b0;
          have_lo_r <= 1'b0;
          lo_r <= 8'h00;
          rem_r <= 8'h00;
          pop_r <= 1'b0;
          wcnt_r <= 8'h00;
          wait_r <= 1'b0;
          push_r <= 1'b0;
          two_r <= 1'b0;
          txd_r <= 16'h0000;
        end else begin
          req_r <= req_nxt;
          pop_r <= take;
          push_r <= xfer & tx;
          if (xfer & ~demand) begin
            gap_r <= gap_load;
          end else if (gap_r != 12'h000) begin
            gap_r <= gap_r - 12'h001;
          end
          // A packet is only picked up once its ready flag is seen.
          if (~rx_act_r & ~done_r & en & ~tx & rx_pkt_ready[ep]) begin
            rx_act_r <= 1'b1;
            rem_r <= cnt_in;
            ins_r <= ctl[`CTL_INS];
            have_lo_r <= 1'b0;
          end else if (rx_act_r) begin
            if (ins_r & bin_ready) begin
              ins_r <= 1'b0;
            end
            if (take) begin
              rem_r <= rem_r - 8'h01;
              have_lo_r <= hold_lo;
              lo_r <= byte_in;
            end
            if (rx_end) begin
              rx_act_r <= 1'b0;
              done_r <= 1'b1;
            end
          end
          if (done_r & ~rx_pkt_ready[ep]) begin
            done_r <= 1'b0;
          end
          if (xfer & tx) begin
            txd_r <= wide ? dma_data_i : {8'h00, dma_data_i[7:0]};
            two_r <= wide;
            wcnt_r <= full ? 8'h00 : wsum[7:0];
          end
          if (set_c) begin
            wait_r <= 1'b1;
          end else if (wait_r & tx_pkt_ready[ep]) begin
            wait_r <= 1'b0;
          end
        end
      end

      assign req_raw[c] = req_r;
      assign set_w[c] = set_c;
      assign busy_w[c] = rx_act_r | wait_r;
      assign bout_w[c*16 +: 16] = bout_data;
      assign rxf_pop[c] = pop_r;
      assign txf_push[c] = push_r;
      assign txf_two[c] = two_r;
      assign txf_data[c*16 +: 16] = txd_r;
    end
  endgenerate

  wire req1_eff = same_ep ? req_raw[0] : req_raw[1];

  always @(posedge mclk) begin
    if (reset) begin
      dma_req_ch0 <= 1'b1;
      dma_req_ch1 <= 1'b1;
      irq_out <= 1'b1;
      dma_data_o <= 16'h0000;
      chan_ep <= 4'h0;
      tx_set_pkt_ready <= 4'h0;
      latch_or_pullup_pin_o <= 1'b0;
      latch_or_pullup_pin_oe <= 1'b0;
    end else begin
      dma_req_ch0 <= ~req_raw[0] ^ pol_r[`POL_REQ0];
      dma_req_ch1 <= ~req1_eff ^ pol_r[`POL_REQ1];
      irq_out <= ~irq_src ^ pol_r[`POL_IRQ];
      dma_data_o <= (ack1_lvl & ~same_ep) ? bout_w[31:16] : bout_w[15:0];
      chan_ep <= {ctl_r[14:13], ctl_r[6:5]};
      tx_set_pkt_ready <= ({3'h0, set_w[0]} << ctl_r[6:5]) |
                          ({3'h0, set_w[1]} << ctl_r[14:13]);
      latch_or_pullup_pin_o <= dplus_pullup_ctrl & ~mux;
      latch_or_pullup_pin_oe <= ~mux;
    end
  end
endmodule

// >>> usb_dma_regs.vh
// Register offsets, field positions, reset values and timing of the DMA request port.
`ifndef USB_DMA_REGS_VH
`define USB_DMA_REGS_VH
`define OFF_CH0_CTL 7'h10
`define OFF_CH0_INTVL 7'h11
`define OFF_CH1_CTL 7'h12
`define OFF_CH1_INTVL 7'h13
`define OFF_POLARITY 7'h30
`define OFF_DMA_STATUS 7'h31
`define CTL_EN 0
`define CTL_DUAL 1
`define CTL_INS 2
`define CTL_WIDE 3
`define CTL_DEMAND 4
`define CTL_EP_LO 5
`define CTL_EP_HI 6
`define CTL_PAUSE 7
`define POL_REQ0 0
`define POL_REQ1 1
`define POL_ACK0 2
`define POL_ACK1 3
`define POL_IRQ 4
`define RST_CTL 8'h00
`define RST_INTVL 8'h00
`define RST_POL 8'h00
`define MCLK_PERIOD_NS 20
`define BIT_TIME_NS 84
`define REQ_EN_TIME_NS 20
`define BIT_CYC ((`BIT_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define REQ_EN_CYC ((`REQ_EN_TIME_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

// >>> dma_buf2.v
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns
module dma_buf2 #(
  parameter W = 16
) (
  input wire mclk,
  input wire reset,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] d0_r;
  reg [W-1:0] d1_r;
  reg v0_r;
  reg v1_r;
  wire push = in_valid & ~v1_r;
  wire pop = v0_r & out_ready;

  assign in_ready = ~v1_r;
  assign out_valid = v0_r;
  assign out_data = d0_r;

  always @(posedge mclk) begin
    if (reset) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= {W{1'b0}};
      d1_r <= {W{1'b0}};
    end else if (pop) begin
      if (v1_r) begin
        d0_r <= d1_r;
        v1_r <= 1'b0;
      end else if (push) begin
        d0_r <= in_data;
      end else begin
        v0_r <= 1'b0;
      end
    end else if (push) begin
      if (v0_r) begin
        d1_r <= in_data;
        v1_r <= 1'b1;
      end else begin
        d0_r <= in_data;
        v0_r <= 1'b1;
      end
    end
  end
endmodule

// >>> usb_dma_port_chk.sv
// Assertion checker bound to the DMA request port.
`timescale 1ns/1ns
module usb_dma_port_chk (
  input wire mclk,
  input wire reset,
  input wire bus_mux_select_pin,
  input wire latch_or_pullup_pin_o,
  input wire latch_or_pullup_pin_oe,
  input wire dplus_pullup_ctrl,
  input wire [6:0] reg_addr,
  input wire cs_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire dma_req_ch0,
  input wire dma_req_ch1,
  input wire xfer_strobe,
  input wire irq_src,
  input wire irq_out
);
  reg [7:0] c0_r, c1_r, pol_r;
  wire sel = !cs_n && !bus_mux_select_pin;
  wire irq_pol = pol_r[4];
  // Shadow copies of the control and polarity registers.
  always @(posedge mclk) begin
    if (reset) begin
      c0_r <= 8'h00;
      c1_r <= 8'h00;
      pol_r <= 8'h00;
    end else if (reg_wr && sel) begin
      case (reg_addr)
        7'h10: c0_r <= reg_wdata;
        7'h12: c1_r <= reg_wdata;
        7'h30: pol_r <= {3'h0, reg_wdata[4:0]};
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  AST_RESET: assert property (disable iff (1'b0)
    reset |=> dma_req_ch0 && dma_req_ch1 && irq_out) else $error("bad reset level");
  AST_PULLUP: assert property (!bus_mux_select_pin ##1 !bus_mux_select_pin |->
    latch_or_pullup_pin_oe && latch_or_pullup_pin_o == $past(dplus_pullup_ctrl))
    else $error("pull-up pin wrong");
  AST_POLRD: assert property (reg_rd && sel && reg_addr == 7'h30 |=>
    reg_rdata == $past(pol_r)) else $error("polarity readback");
  AST_DIS0: assert property ((!c0_r[0] && $stable(pol_r))[*3] |->
    dma_req_ch0 == !pol_r[0]) else $error("request while disabled");
  AST_PAUSE0: assert property ((c0_r[7] && $stable(pol_r))[*3] |->
    dma_req_ch0 == !pol_r[0]) else $error("request while paused");
  AST_SAME: assert property ((c0_r[6:5] == c1_r[6:5] && pol_r[0] == pol_r[1]) [*2] |->
    dma_req_ch0 == dma_req_ch1) else $error("shared endpoint pins differ");
  AST_IRQ: assert property (!$past(reset) |->
    irq_out == ($past(irq_src) ^ !$past(irq_pol))) else $error("irq level");
  AST_GAP: assert property (xfer_strobe && dma_req_ch0 == pol_r[0] && c0_r[0] && !c0_r[4]
    |-> ##[1:2] dma_req_ch0 != pol_r[0]) else $error("single request not dropped");
endmodule
bind usb_dma_port usb_dma_port_chk u_usb_dma_port_chk (.*);

// >>> dma_ctl_model.sv
// Behavioural DMA controller on the far side of channel 0.
`timescale 1ns/1ns
module dma_ctl_model (
  input wire mclk,
  input wire reset,
  input wire go,
  input wire req,
  output reg ack = 1'b0,
  output reg strobe = 1'b0
);
  reg [1:0] wait_r = 2'd0;
  // A quiet spell after each strobe keeps strobes apart.
  always @(posedge mclk) begin
    if (reset || !go) begin
      ack <= 1'b0;
      strobe <= 1'b0;
      wait_r <= 2'd0;
    end else if (strobe) begin
      ack <= 1'b0;
      strobe <= 1'b0;
      wait_r <= 2'd3;
    end else if (wait_r != 2'd0) begin
      wait_r <= wait_r - 2'd1;
    end else if (!req) begin
      ack <= 1'b1;
      strobe <= 1'b1;
    end
  end
endmodule

// >>> test_usb_dma_port.sv
// Self-checking bench of the DMA request port.
`timescale 1ns/1ns
module test_usb_dma_port;
  reg mclk = 1'b0, reset = 1'b1, bus_mux_select_pin = 1'b0, latch_or_pullup_pin_i = 1'b0;
  reg dplus_pullup_ctrl = 1'b0, cs_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg irq_src = 1'b0, dma_ack_ch1 = 1'b0, go = 1'b0;
  reg [7:0] ad_in = 8'h00, reg_wdata = 8'h00, idx = 8'h00;
  reg [6:0] reg_addr = 7'h00;
  reg [15:0] dma_data_i = 16'h0000;
  reg [3:0] ep_is_tx = 4'h0, tx_fifo_free = 4'h0, tx_pkt_ready = 4'h0, rx_pkt_ready = 4'h0;
  reg [31:0] rx_byte_count = 32'h00000300, max_pkt_size = 32'h00000000;
  wire latch_or_pullup_pin_o, latch_or_pullup_pin_oe, dma_req_ch0, dma_req_ch1, irq_out;
  wire dma_ack_ch0, xfer_strobe;
  wire [7:0] reg_rdata;
  wire [15:0] dma_data_o;
  wire [3:0] chan_ep, tx_set_pkt_ready;
  wire [1:0] rxf_pop, txf_push, txf_two;
  wire [31:0] txf_data;
  wire [1:0] rxf_valid = {1'b0, idx < 8'h03};
  wire [15:0] rxf_data = {8'h00, 8'ha0 + idx};
  reg [15:0] got [0:7];
  integer n_got = 0, run = 0, min_gap = 99, fail_count = 0, n_compared = 0, i;
  integer n_push = 0, n_set = 0;
  usb_dma_port u_usb_dma_port (.*);
  dma_ctl_model u_dma_ctl_model (.mclk(mclk), .reset(reset), .go(go), .req(dma_req_ch0),
    .ack(dma_ack_ch0), .strobe(xfer_strobe));
  always #10 mclk = ~mclk;
  // Receive FIFO head, captured words and the shortest idle run of the request.
  always @(posedge mclk) begin
    if (rxf_pop[0])
      idx <= idx + 8'h01;
    if (txf_push[0])
      n_push <= n_push + 1;
    if (tx_set_pkt_ready[0])
      n_set <= n_set + 1;
    if (xfer_strobe && n_got < 8) begin
      got[n_got] <= dma_data_o;
      n_got <= n_got + 1;
    end
    if (dma_req_ch0 === 1'b1)
      run <= run + 1;
    else begin
      if (run > 0 && run < min_gap)
        min_gap <= run;
      run <= 0;
    end
  end
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task cmp(input [15:0] g, input [15:0] e);
    n_compared = n_compared + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(input [6:0] a, input [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [6:0] a, input [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    cmp(reg_rdata, e);
  endtask
  task wait_got(input integer n);
    integer k;
    for (k = 0; k < 500 && n_got < n; k = k + 1)
      @(posedge mclk);
    if (n_got < n) begin
      fail_count = fail_count + 1;
      conclude;
    end
  endtask
  initial begin
    tick(3);
    reset <= 1'b0;
    @(negedge mclk);
    cmp({dma_req_ch0, dma_req_ch1, irq_out}, 3'b111);
    for (i = 0; i < 4; i = i + 1) begin
      rd(7'h10 + i[6:0], 8'h00);
      wr(7'h10 + i[6:0], 8'h5a);
      rd(7'h10 + i[6:0], 8'h5a);
      wr(7'h10 + i[6:0], 8'h00);
    end
    wr(7'h20, 8'h5a);
    rd(7'h20, 8'h00);
    rd(7'h30, 8'h00);
    wr(7'h30, 8'h1f);
    rd(7'h30, 8'h1f);
    tick(2);
    @(negedge mclk);
    cmp({dma_req_ch0, dma_req_ch1, irq_out}, 3'b000);
    @(posedge mclk);
    irq_src <= 1'b1;
    dplus_pullup_ctrl <= 1'b1;
    wr(7'h30, 8'h00);
    tick(2);
    @(negedge mclk);
    cmp({irq_out, latch_or_pullup_pin_oe, latch_or_pullup_pin_o}, 3'b011);
    @(posedge mclk);
    irq_src <= 1'b0;
    bus_mux_select_pin <= 1'b1;
    tick(2);
    @(negedge mclk);
    cmp(latch_or_pullup_pin_oe, 1'b0);
    @(posedge mclk);
    ad_in <= 8'h11;
    latch_or_pullup_pin_i <= 1'b1;
    @(posedge mclk);
    latch_or_pullup_pin_i <= 1'b0;
    wr(7'h00, 8'h07);
    rd(7'h00, 8'h07);
    @(posedge mclk);
    bus_mux_select_pin <= 1'b0;
    rx_pkt_ready <= 4'b0010;
    go <= 1'b1;
    wr(7'h11, 8'h02);
    wr(7'h10, 8'h24);
    tick(20);
    cmp(n_got[15:0], 16'h0000);
    wr(7'h10, 8'ha5);
    tick(20);
    cmp(n_got[15:0], 16'h0000);
    wr(7'h10, 8'h25);
    wait_got(4);
    @(posedge mclk);
    rx_pkt_ready <= 4'b0000;
    tick(20);
    @(negedge mclk);
    cmp({n_got[14:0], dma_req_ch0}, 16'h0009);
    cmp(got[0], 16'h0003);
    for (i = 0; i < 3; i = i + 1)
      cmp(got[i + 1], {8'h00, 8'ha0 + i[7:0]});
    cmp(min_gap >= 11, 1'b1);
    @(posedge mclk);
    ep_is_tx <= 4'b0001;
    tx_fifo_free <= 4'b0001;
    max_pkt_size <= 32'h00000002;
    dma_data_i <= 16'h5ac5;
    wr(7'h10, 8'h11);
    tick(30);
    @(negedge mclk);
    cmp({n_push[7:0], n_set[6:0], dma_req_ch0}, 16'h0203);
    cmp(txf_data[15:0], 16'h00c5);
    @(posedge mclk);
    tx_pkt_ready <= 4'b0001;
    tick(10);
    @(negedge mclk);
    cmp(dma_req_ch0, 1'b1);
    @(posedge mclk);
    tx_pkt_ready <= 4'b0000;
    for (i = 0; i < 100 && n_push < 3; i = i + 1)
      @(posedge mclk);
    tx_pkt_ready <= 4'b0001;
    tick(20);
    @(negedge mclk);
    cmp({n_push[7:0], n_set[6:0], dma_req_ch0}, 16'h0303);
    conclude;
  end
endmodule
